// >>> hw/dsadc_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef DSADC_DEFS_SVH
`define DSADC_DEFS_SVH

`define ADDR_COUNT_LOW      8'hF7
`define ADDR_COUNT_MID      8'hF8
`define ADDR_COUNT_HIGH     8'hF9
`define ADDR_COUNT_MSB_POL  8'hFA
`define ADDR_READ_VALIDITY  8'hFB
`define ADDR_DONE_FLAG      8'hC4
`define ADDR_DONE_MASK      8'hC8
`define ADDR_RESOLUTION     8'hF3
`define ADDR_MODE_SELECT    8'hF4
`define ADDR_RUN            8'hF6

`define BIT_RUN             3
`define BIT_DONE_MASK       2
`define BIT_DONE_FLAG       0
`define BIT_READ_INVALID    0
`define BIT_POLARITY        1
`define BIT_COUNT_MSB       0

`define RST_NIBBLE          4'h0
`define RST_COUNT           13'h0000

`define RES_COUNT_0         13'd6552
`define RES_COUNT_1         13'd3276
`define RES_COUNT_2         13'd1638
`define RES_COUNT_3         13'd820

`define REF_CLK_HZ          50000000
`define SLOW_CLK_HZ         32768
`define SLOW_DIV_CYCLES     (`REF_CLK_HZ / `SLOW_CLK_HZ)

`endif

// >>> hw/dsadc_pkg.sv
// Types shared by the converter sequencer
package dsadc_pkg;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0001,
		ST_AUTO_ZERO = 4'b0010,
		ST_INPUT_INT = 4'b0100,
		ST_REVERSE   = 4'b1000
	} phase_e;

	typedef enum logic [1:0] {
		MODE_VOLTAGE    = 2'h0,
		MODE_DIFF_LOW   = 2'h1,
		MODE_DIFF_HIGH  = 2'h2,
		MODE_RESISTANCE = 2'h3
	} meas_mode_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [3:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

	typedef struct packed {
		logic int_plus_ground;
		logic int_plus_ain0;
		logic int_plus_ain2;
		logic ref_voltage;
		logic ref_resistance;
		logic ain4_drive;
		logic ref_negative;
		logic auto_zero_sw;
		logic input_sw;
		logic reverse_sw;
		logic power_on;
	} analog_ctrl_s;

endpackage

// >>> hw/dual_slope_adc_sequencer.sv
// Dual-slope converter sequencer with nibble register port
`timescale 1ns/100ps
`default_nettype none
`include "dsadc_defs.svh"

module dual_slope_adc_sequencer
#(
	parameter int SLOW_DIV = `SLOW_DIV_CYCLES
)
(
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic [7:0]              addr,
	input  wire logic [3:0]              wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic [3:0]                   rdata,
	input  wire logic                    comparator_pos,
	output logic                         irq,
	output dsadc_pkg::analog_ctrl_s      analog_ctrl
);
	import dsadc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]   cmp_sync;
		logic         cmp_filt;
		logic [15:0]  div_cnt;
		logic         tick;
		phase_e       phase;
		logic [12:0]  phase_cnt;
		logic [12:0]  count;
		logic         neg_ref;
		logic [12:0]  latch;
		logic         polarity;
		logic         run;
		logic         done_flag;
		logic         done_mask;
		logic [1:0]   resolution;
		logic [3:0]   mode_sel;
		logic [2:0]   read_step;
		logic         read_invalid;
		logic [3:0]   rdata;
		logic         irq;
		analog_ctrl_s actl;
	} state_s;

	state_s state_reg;
	state_s state_next;
	logic [12:0] full_scale;
	logic [12:0] half_scale;
	logic        cmp_pos;
	logic        conv_done;
	logic        run_start;
	meas_mode_e  mode;

	// ----------------------------------------
	// Resolution and mode decode
	// ----------------------------------------
	always_comb
	begin
		case (state_reg.resolution)
			2'h0: full_scale = `RES_COUNT_0;
			2'h1: full_scale = `RES_COUNT_1;
			2'h2: full_scale = `RES_COUNT_2;
			default: full_scale = `RES_COUNT_3;
		endcase
		half_scale = {1'b0, full_scale[12:1]};
		if (state_reg.mode_sel[3] || state_reg.mode_sel[2])
			mode = MODE_RESISTANCE;
		else if (state_reg.mode_sel[1])
			mode = MODE_DIFF_HIGH;
		else if (state_reg.mode_sel[0])
			mode = MODE_DIFF_LOW;
		else
			mode = MODE_VOLTAGE;
	end

	assign cmp_pos = state_reg.cmp_filt;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		state_next = state_reg;
		conv_done = 1'b0;
		run_start = wr && (addr == `ADDR_RUN) && wdata[`BIT_RUN];

		// Comparator input synchroniser
		state_next.cmp_sync = {state_reg.cmp_sync[1:0], comparator_pos};
		// Level accepted once second and third stages agree
		if (state_reg.cmp_sync[2] == state_reg.cmp_sync[1])
			state_next.cmp_filt = state_reg.cmp_sync[2];

		// Slow clock enable
		state_next.tick = 1'b0;
		if (state_reg.div_cnt >= 16'(SLOW_DIV - 1))
		begin
			state_next.div_cnt = 16'h0000;
			state_next.tick = 1'b1;
		end
		else
			state_next.div_cnt = state_reg.div_cnt + 16'h0001;

		// Conversion sequence
		if (state_reg.tick && state_reg.run)
		begin
			case (state_reg.phase)
				ST_AUTO_ZERO:
				begin
					if (state_reg.phase_cnt >= full_scale - 13'h0001)
					begin
						state_next.phase = ST_INPUT_INT;
						state_next.phase_cnt = 13'h0000;
					end
					else
						state_next.phase_cnt = state_reg.phase_cnt + 13'h0001;
				end
				ST_INPUT_INT:
				begin
					state_next.neg_ref = cmp_pos;
					if (state_reg.phase_cnt >= half_scale - 13'h0001)
					begin
						state_next.phase = ST_REVERSE;
						state_next.phase_cnt = 13'h0000;
						state_next.count = `RST_COUNT;
					end
					else
						state_next.phase_cnt = state_reg.phase_cnt + 13'h0001;
				end
				ST_REVERSE:
				begin
					if (cmp_pos != state_reg.neg_ref || state_reg.count >= full_scale)
					begin
						conv_done = 1'b1;
						state_next.phase = ST_AUTO_ZERO;
						state_next.phase_cnt = 13'h0000;
					end
					else
						state_next.count = state_reg.count + 13'h0001;
				end
				default:
				begin
					state_next.phase = ST_AUTO_ZERO;
					state_next.phase_cnt = 13'h0000;
				end
			endcase
		end

		// Result latch and ordered-read monitor
		if (conv_done)
		begin
			state_next.latch = state_reg.count;
			state_next.polarity = state_reg.neg_ref;
			if (state_reg.read_step != 3'h0)
				state_next.read_invalid = 1'b1;
			state_next.read_step = 3'h1;
		end

		// Register reads
		state_next.rdata = `RST_NIBBLE;
		if (rd)
		begin
			if (addr == `ADDR_COUNT_LOW)
			begin
				state_next.rdata = state_reg.latch[3:0];
				if (!conv_done)
				begin
					state_next.read_step = 3'h2;
					state_next.read_invalid = 1'b0;
				end
			end
			else if (addr == `ADDR_COUNT_MID)
			begin
				state_next.rdata = state_reg.latch[7:4];
				if (!conv_done && state_reg.read_step == 3'h2)
					state_next.read_step = 3'h3;
			end
			else if (addr == `ADDR_COUNT_HIGH)
			begin
				state_next.rdata = state_reg.latch[11:8];
				if (!conv_done && state_reg.read_step == 3'h3)
					state_next.read_step = 3'h4;
			end
			else if (addr == `ADDR_COUNT_MSB_POL)
			begin
				state_next.rdata[`BIT_COUNT_MSB] = state_reg.latch[12];
				state_next.rdata[`BIT_POLARITY] = state_reg.polarity;
				if (!conv_done && state_reg.read_step == 3'h4)
					state_next.read_step = 3'h0;
			end
			else if (addr == `ADDR_READ_VALIDITY)
				state_next.rdata[`BIT_READ_INVALID] = state_reg.read_invalid;
			else if (addr == `ADDR_DONE_FLAG)
			begin
				state_next.rdata[`BIT_DONE_FLAG] = state_reg.done_flag;
				state_next.done_flag = 1'b0;
			end
			else if (addr == `ADDR_DONE_MASK)
				state_next.rdata[`BIT_DONE_MASK] = state_reg.done_mask;
			else if (addr == `ADDR_RESOLUTION)
				state_next.rdata[1:0] = state_reg.resolution;
			else if (addr == `ADDR_MODE_SELECT)
				state_next.rdata = state_reg.mode_sel;
			else if (addr == `ADDR_RUN)
				state_next.rdata[`BIT_RUN] = state_reg.run;
		end

		// Done flag: set wins over read clear
		if (conv_done)
			state_next.done_flag = 1'b1;

		// Register writes
		if (wr)
		begin
			if (addr == `ADDR_DONE_MASK)
				state_next.done_mask = wdata[`BIT_DONE_MASK];
			else if (addr == `ADDR_RESOLUTION)
				state_next.resolution = wdata[1:0];
			else if (addr == `ADDR_MODE_SELECT)
				state_next.mode_sel = wdata;
			else if (addr == `ADDR_RUN)
			begin
				state_next.run = wdata[`BIT_RUN];
				if (run_start)
				begin
					state_next.phase = ST_AUTO_ZERO;
					state_next.phase_cnt = 13'h0000;
					state_next.count = `RST_COUNT;
				end
				else
					state_next.phase = ST_IDLE;
			end
		end

		state_next.irq = state_next.done_flag && state_next.done_mask;

		// Analog switch and reference control
		state_next.actl.power_on = state_next.run;
		state_next.actl.int_plus_ground = (mode == MODE_VOLTAGE) ||
			(mode == MODE_RESISTANCE);
		state_next.actl.int_plus_ain0 = (mode == MODE_DIFF_LOW);
		state_next.actl.int_plus_ain2 = (mode == MODE_DIFF_HIGH);
		state_next.actl.ref_voltage = (mode != MODE_RESISTANCE);
		state_next.actl.ref_resistance = (mode == MODE_RESISTANCE);
		state_next.actl.ain4_drive = (mode == MODE_RESISTANCE) && state_next.run;
		state_next.actl.ref_negative = state_next.neg_ref;
		state_next.actl.auto_zero_sw = state_next.run && (state_next.phase == ST_AUTO_ZERO);
		state_next.actl.input_sw = state_next.run && (state_next.phase == ST_INPUT_INT);
		state_next.actl.reverse_sw = state_next.run && (state_next.phase == ST_REVERSE);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= '0;
			state_reg.phase <= ST_IDLE;
		end
		else
			state_reg <= state_next;
	end

	assign rdata = state_reg.rdata;
	assign irq = state_reg.irq;
	assign analog_ctrl = state_reg.actl;

endmodule
`default_nettype wire

// >>> bench/dsadc_checker_properties.sv
// Port-level checks of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module dsadc_checker
#(
	parameter int SLOW_DIV = 4
)
(
	input wire logic                    ref_clk,
	input wire logic                    rst,
	input wire logic [7:0]              addr,
	input wire logic [3:0]              wdata,
	input wire logic                    wr,
	input wire logic                    rd,
	input wire logic [3:0]              rdata,
	input wire logic                    comparator_pos,
	input wire logic                    irq,
	input wire dsadc_pkg::analog_ctrl_s analog_ctrl
);
	import dsadc_pkg::*;
	logic [1:0]  res_reg;
	logic [15:0] in_cnt_reg;
	logic [15:0] rev_cnt_reg;
	logic [15:0] fs;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	assign fs = res_reg == 2'h0 ? 16'h1998 : res_reg == 2'h1 ? 16'h0CCC :
		res_reg == 2'h2 ? 16'h0666 : 16'h0334;
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
		begin
			res_reg <= 2'h0;
			in_cnt_reg <= 16'h0000;
			rev_cnt_reg <= 16'h0000;
		end
		else
		begin
			if (wr && addr == 8'hF3)
				res_reg <= wdata[1:0];
			in_cnt_reg <= analog_ctrl.input_sw ? in_cnt_reg + 16'h0001 : 16'h0000;
			rev_cnt_reg <= analog_ctrl.reverse_sw ? rev_cnt_reg + 16'h0001 : 16'h0000;
		end
	sequence s_run_on;
		wr && addr == 8'hF6 && wdata[3];
	endsequence
	sequence s_fresh;
		analog_ctrl.power_on && analog_ctrl.auto_zero_sw && !analog_ctrl.reverse_sw;
	endsequence
	a_rdata_idle: assert property (!rd |=> rdata == 4'h0)
		else $error("read data not idle");
	a_run_on: assert property (s_run_on |=> s_fresh)
		else $error("run write did not restart");
	a_run_read: assert property (
		rd && addr == 8'hF6 |=> rdata[3] == $past(analog_ctrl.power_on))
		else $error("run bit read wrong");
	a_stop_idle: assert property (!analog_ctrl.power_on |-> analog_ctrl[3:1] == 3'h0)
		else $error("phase active while off");
	a_rev_loop: assert property (
		$fell(analog_ctrl.reverse_sw) && analog_ctrl.power_on |-> analog_ctrl.auto_zero_sw)
		else $error("no return to auto zero");
	a_input_len: assert property (
		$fell(analog_ctrl.input_sw) && analog_ctrl.reverse_sw |-> in_cnt_reg == fs / 2 * SLOW_DIV)
		else $error("input phase length wrong");
	a_rev_bound: assert property (
		analog_ctrl.reverse_sw |-> rev_cnt_reg <= (fs + 16'h0001) * SLOW_DIV)
		else $error("reverse phase too long");
	a_mode_volt: assert property (
		wr && addr == 8'hF4 && wdata == 4'h0 |-> ##2 analog_ctrl.int_plus_ground && analog_ctrl.ref_voltage)
		else $error("voltage mode wrong");
	a_mode_diff: assert property (
		wr && addr == 8'hF4 && wdata == 4'h1 |-> ##2 analog_ctrl.int_plus_ain0 && analog_ctrl.ref_voltage)
		else $error("differential mode wrong");
	a_mode_res: assert property (
		wr && addr == 8'hF4 && wdata[3:2] != 2'h0 |-> ##2 analog_ctrl.ref_resistance)
		else $error("resistance mode wrong");
endmodule
bind dual_slope_adc_sequencer dsadc_checker #(.SLOW_DIV(SLOW_DIV)) chk
(
	.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .comparator_pos(comparator_pos), .irq(irq), .analog_ctrl(analog_ctrl)
);
`default_nettype wire

// >>> bench/dual_slope_adc_sequencer_tb.sv
// Directed testbench of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module dual_slope_adc_sequencer_tb;
	import dsadc_pkg::*;
	logic         ref_clk = 1'b0;
	logic         rst = 1'b1;
	logic [7:0]   addr = 8'h00;
	logic [3:0]   wdata = 4'h0;
	logic         wr = 1'b0;
	logic         rd = 1'b0;
	logic         comp = 1'b0;
	logic [3:0]   rdata;
	logic         irq;
	analog_ctrl_s actl;
	int           failures = 0;
	int           n_compared = 0;
	logic [15:0]  v;
	logic [3:0]   d;
	always #10 ref_clk = ~ref_clk;
	dual_slope_adc_sequencer #(.SLOW_DIV(4)) uut
	(
		.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .comparator_pos(comp), .irq(irq), .analog_ctrl(actl)
	);
	task automatic check(input string what, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [3:0] x);
		@(posedge ref_clk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic get_result();
		for (int i = 0; i < 4; i++)
		begin
			rreg(8'hF7 + 8'(i));
			v[i*4 +: 4] = d;
		end
	endtask
	task automatic wait_rev(input logic lvl, input int n);
		for (int i = 0; i < n && actl.reverse_sw !== lvl; i++)
			@(negedge ref_clk);
	endtask
	task automatic conv(input int k, input logic pol);
		@(posedge ref_clk);
		comp <= pol;
		wait_rev(1'b1, 20000);
		wait_rev(1'b0, k * 4);
		@(posedge ref_clk);
		comp <= !pol;
		wait_rev(1'b0, 5000);
		@(posedge ref_clk);
		comp <= pol;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic t_regs();
		logic [7:0] ra [11] = '{8'hF3, 8'hF4, 8'hF6, 8'hF7, 8'hF8, 8'hF9, 8'hFA, 8'hFB,
			8'hC4, 8'hC8, 8'h10};
		wreg(8'h10, 4'hF);
		foreach (ra[i])
		begin
			rreg(ra[i]);
			check("reset read", d, 4'h0);
		end
		wreg(8'hC8, 4'h4);
		wreg(8'hF3, 4'h3);
		rreg(8'hF3);
		check("resolution", d, 4'h3);
	endtask
	task automatic t_modes();
		logic [3:0] m [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
		logic [4:0] e [5] = '{5'h0A, 5'h06, 5'h11, 5'h11, 5'h12};
		foreach (m[i])
		begin
			wreg(8'hF4, m[i]);
			repeat (2) @(posedge ref_clk);
			#1;
			check("mode", actl[10:6], e[i]);
		end
	endtask
	task automatic t_conv();
		wreg(8'hF6, 4'h8);
		rreg(8'hF6);
		check("run", {d[3], actl.power_on}, 2'h3);
		conv(100, 1'b1);
		check("irq", irq, 1'b1);
		check("ref sign", actl.ref_negative, 1'b1);
		get_result();
		check("count", v[12:0] >= 13'h0063 && v[12:0] <= 13'h0066, 1'b1);
		check("polarity", v[15:13], 3'h1);
		rreg(8'hFB);
		check("valid", d, 4'h0);
		rreg(8'hC4);
		check("flag", d, 4'h1);
		rreg(8'hC4);
		check("flag clear", {d, irq}, 5'h00);
	endtask
	task automatic t_full();
		wreg(8'hC8, 4'h0);
		conv(1000, 1'b0);
		check("masked irq", irq, 1'b0);
		check("ref sign low", actl.ref_negative, 1'b0);
		get_result();
		check("full scale", v[12:0] >= 13'h0333 && v[12:0] <= 13'h0334, 1'b1);
		check("negative", v[15:13], 3'h0);
		rreg(8'hC4);
		check("masked flag", d, 4'h1);
	endtask
	task automatic t_invalid();
		conv(50, 1'b1);
		rreg(8'hF7);
		conv(60, 1'b1);
		rreg(8'hF8);
		rreg(8'hF9);
		rreg(8'hFA);
		rreg(8'hFB);
		check("invalid", d, 4'h1);
		get_result();
		check("rewritten", v[12:0] >= 13'h003B && v[12:0] <= 13'h003E, 1'b1);
		rreg(8'hFB);
		check("valid again", d, 4'h0);
	endtask
	task automatic t_restart();
		wait_rev(1'b1, 20000);
		wreg(8'hF6, 4'h8);
		check("restart", actl[3:0], 4'h9);
		wreg(8'hF4, 4'h4);
		@(posedge ref_clk);
		#1;
		check("ain4 drive", actl.ain4_drive, 1'b1);
		wreg(8'hF4, 4'h0);
		wreg(8'hF6, 4'h0);
		rreg(8'hF6);
		check("stopped", {d[3], actl[3:0]}, 5'h00);
		rreg(8'hFB);
		check("stop valid", d, 4'h0);
	endtask
	task automatic close_out();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs();
		t_modes();
		t_conv();
		t_full();
		t_invalid();
		t_restart();
		close_out();
	end
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
